// file: logic/requester_tag_credit_ordering.sv
// requester tag allocation, pending table, credit counts and posted ordering
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module requester_tag_credit_ordering (
   input wire logic clk,
   input wire logic reset,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic req_stream_valid,
   output logic req_stream_ready,
   input wire tag_credit_pkg::sideband_t req_stream_sideband,
   input wire logic [63:0] req_stream_payload,
   input wire logic req_stream_last,
   output logic link_valid,
   input wire logic link_ready,
   output tag_credit_pkg::beat_t link_beat,
   input wire logic [3:0] nph_credit_return,
   input wire logic [3:0] npd_credit_return,
   input wire tag_credit_pkg::cpl_t cpl_in,
   output logic cpl_hit_valid,
   output logic cpl_hit,
   output logic [7:0] alloc_tag_first,
   output logic [7:0] alloc_tag_second,
   output logic alloc_tag_first_valid,
   output logic alloc_tag_second_valid,
   output logic [3:0] np_header_credit_count,
   output logic [3:0] np_data_credit_count,
   output logic [3:0] free_tag_count,
   output logic [5:0] posted_seq_out_first,
   output logic [5:0] posted_seq_out_second,
   output logic posted_seq_out_first_valid,
   output logic posted_seq_out_second_valid
);
   import tag_credit_pkg::*;

   function automatic logic slot_np(input slot_t s);
      return s.start && s.np;
   endfunction

   function automatic logic slot_posted(input slot_t s);
      return s.start && !s.np;
   endfunction

   function automatic logic [3:0] sat4(input logic [8:0] v);
      return (v > CNT_SAT_WIDE) ? CNT_SAT : v[3:0];
   endfunction

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   logic internal_q;
   logic straddle_q;
   logic aw_got_q;
   logic w_got_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic [8:0] out_cnt_q;
   logic [8:0] free_cnt;
   logic [7:0] hdr_q;
   logic [7:0] data_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         awready <= 1'b0;
         wready <= 1'b0;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         internal_q <= CTRL_INTERNAL_RST;
         straddle_q <= CTRL_STRADDLE_RST;
      end else begin
         awready <= awvalid && !awready && !aw_got_q && !bvalid;
         wready <= wvalid && !wready && !w_got_q && !bvalid;
         if (awvalid && awready) begin
            aw_got_q <= 1'b1;
            waddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_q <= 1'b1;
            wdata_q <= wdata;
            wstrb0_q <= wstrb[0];
         end
         if (aw_got_q && w_got_q && !bvalid) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= RESP_OKAY;
            if (waddr_q == ADDR_CTRL) begin
               if (wstrb0_q) begin
                  internal_q <= wdata_q[CTRL_INTERNAL_POS];
                  straddle_q <= wdata_q[CTRL_STRADDLE_POS];
               end
            end else if (waddr_q != ADDR_STATUS && waddr_q != ADDR_CREDIT) begin
               bresp <= RESP_SLVERR;
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
            unique case (araddr)
               ADDR_CTRL: begin
                  rdata[CTRL_INTERNAL_POS] <= internal_q;
                  rdata[CTRL_STRADDLE_POS] <= straddle_q;
               end
               ADDR_STATUS: begin
                  rdata[8:0] <= out_cnt_q;
                  rdata[STATUS_FREE_POS +: 9] <= free_cnt;
               end
               ADDR_CREDIT: begin
                  rdata[7:0] <= hdr_q;
                  rdata[CREDIT_NPD_POS +: 8] <= data_q;
               end
               default: rresp <= RESP_SLVERR;
            endcase
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // acceptance and tag choice
   // ----------------------------------------------------------------
   logic acc;
   logic np0;
   logic np1;
   logic [1:0] n_np;
   logic [1:0] n_data;
   logic [1:0] need;
   logic [7:0] fl_tag0;
   logic [7:0] fl_tag1;
   logic [7:0] tag0_sel;
   logic [7:0] tag1_sel;
   logic cpl_final;
   logic cpl_match;
   logic release_tag;
   beat_t in_beat;
   logic [NUM_TAGS-1:0] pend_q;

   assign acc = req_stream_valid && req_stream_ready;
   assign np0 = acc && slot_np(req_stream_sideband.first);
   assign np1 = acc && straddle_q && slot_np(req_stream_sideband.second);
   assign n_np = {1'b0, np0} + {1'b0, np1};
   assign n_data = {1'b0, np0 && req_stream_sideband.first.has_data}
                 + {1'b0, np1 && req_stream_sideband.second.has_data};
   assign need = straddle_q ? 2'd2 : 2'd1;

   // external mode takes the descriptor tag as is, with no uniqueness check
   assign tag0_sel = internal_q ? fl_tag0 : req_stream_sideband.first.tag;
   assign tag1_sel = !internal_q ? req_stream_sideband.second.tag : (np0 ? fl_tag1 : fl_tag0);

   assign cpl_final = cpl_in.valid && cpl_in.last;
   assign cpl_match = pend_q[cpl_in.tag];
   assign release_tag = internal_q && cpl_final && cpl_match;

   tag_free_list u_free_list (
      .clk(clk),
      .reset(reset),
      .pop_cnt(internal_q ? n_np : 2'd0),
      .push(release_tag),
      .push_tag(cpl_in.tag),
      .head_tag0(fl_tag0),
      .head_tag1(fl_tag1),
      .count(free_cnt)
   );

   always_comb begin
      in_beat.payload = req_stream_payload;
      in_beat.last = req_stream_last;
      in_beat.side = req_stream_sideband;
      in_beat.side.first.tag = tag0_sel;
      in_beat.side.second.tag = tag1_sel;
      if (!straddle_q) begin
         in_beat.side.second = '0;
      end
   end

   // ----------------------------------------------------------------
   // pending table and outstanding count
   // ----------------------------------------------------------------
   logic [8:0] out_d;

   // set after clear, so a new request on a just-finished tag is kept
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend_q <= '0;
      end else begin
         if (cpl_final && cpl_match) begin
            pend_q[cpl_in.tag] <= 1'b0;
         end
         if (np0) begin
            pend_q[tag0_sel] <= 1'b1;
         end
         if (np1) begin
            pend_q[tag1_sel] <= 1'b1;
         end
      end
   end

   assign out_d = out_cnt_q + {7'h00, n_np} - {8'h00, cpl_final && cpl_match};

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_cnt_q <= 9'h000;
         cpl_hit_valid <= 1'b0;
         cpl_hit <= 1'b0;
      end else begin
         out_cnt_q <= out_d;
         cpl_hit_valid <= cpl_in.valid;
         cpl_hit <= cpl_in.valid && cpl_match;
      end
   end

   // ----------------------------------------------------------------
   // credits and ready
   // ----------------------------------------------------------------
   logic [8:0] hdr_sum;
   logic [8:0] data_sum;
   logic [7:0] hdr_d;
   logic [7:0] data_d;
   logic [8:0] free_d;
   logic [1:0] bcnt_q;
   logic [1:0] bcnt_d;
   logic res_ok;

   assign hdr_sum = {1'b0, hdr_q} + {5'h00, nph_credit_return} - {7'h00, n_np};
   assign data_sum = {1'b0, data_q} + {5'h00, npd_credit_return} - {7'h00, n_data};
   assign hdr_d = hdr_sum[8] ? CREDIT_MAX : hdr_sum[7:0];
   assign data_d = data_sum[8] ? CREDIT_MAX : data_sum[7:0];
   assign free_d = free_cnt + {8'h00, release_tag} - (internal_q ? {7'h00, n_np} : 9'h000);

   // ready is a flop, so it must reserve room for a full beat: two requests when straddled, one otherwise
   assign res_ok = hdr_d >= {6'h00, need} && data_d >= {6'h00, need}
                && (!internal_q || (free_d >= {7'h00, need}
                && out_d + {7'h00, need} <= TABLE_LIMIT));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hdr_q <= NPH_INIT;
         data_q <= NPD_INIT;
         req_stream_ready <= 1'b0;
         np_header_credit_count <= 4'h0;
         np_data_credit_count <= 4'h0;
         free_tag_count <= 4'h0;
      end else begin
         hdr_q <= hdr_d;
         data_q <= data_d;
         req_stream_ready <= res_ok && bcnt_d <= 2'd1;
         // second stage gives the two-cycle lag behind the transfer
         np_header_credit_count <= sat4({1'b0, hdr_q});
         np_data_credit_count <= sat4({1'b0, data_q});
         free_tag_count <= sat4(internal_q ? free_cnt : 9'h000);
      end
   end

   // ----------------------------------------------------------------
   // tag report
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         alloc_tag_first_valid <= 1'b0;
         alloc_tag_second_valid <= 1'b0;
         alloc_tag_first <= 8'h00;
         alloc_tag_second <= 8'h00;
      end else begin
         // a lone tag always goes out on the first pair, in request order
         alloc_tag_first_valid <= internal_q && (np0 || np1);
         alloc_tag_second_valid <= internal_q && np0 && np1;
         alloc_tag_first <= np0 ? tag0_sel : tag1_sel;
         alloc_tag_second <= tag1_sel;
      end
   end

   // ----------------------------------------------------------------
   // transmit stage and posted ordering point
   // ----------------------------------------------------------------
   beat_t e1_q;
   logic pop;
   logic push_b;

   assign push_b = acc;
   assign pop = link_valid && link_ready;
   assign bcnt_d = bcnt_q + {1'b0, push_b} - {1'b0, pop};

   // two-entry in-order queue keeps acceptance order on the link
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link_beat <= '0;
         e1_q <= '0;
         bcnt_q <= 2'd0;
         link_valid <= 1'b0;
      end else begin
         bcnt_q <= bcnt_d;
         link_valid <= bcnt_d != 2'd0;
         if (pop) begin
            link_beat <= (push_b && bcnt_q == 2'd1) ? in_beat : e1_q;
            if (push_b && bcnt_q == 2'd2) begin
               e1_q <= in_beat;
            end
         end else if (push_b) begin
            if (bcnt_q == 2'd0) begin
               link_beat <= in_beat;
            end else begin
               e1_q <= in_beat;
            end
         end
      end
   end

   // a beat taken by the link can no longer be passed by a completion
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         posted_seq_out_first_valid <= 1'b0;
         posted_seq_out_second_valid <= 1'b0;
         posted_seq_out_first <= 6'h00;
         posted_seq_out_second <= 6'h00;
      end else begin
         posted_seq_out_first_valid <= pop && (slot_posted(link_beat.side.first)
                                     || slot_posted(link_beat.side.second));
         posted_seq_out_second_valid <= pop && slot_posted(link_beat.side.first)
                                      && slot_posted(link_beat.side.second);
         posted_seq_out_first <= slot_posted(link_beat.side.first)
                               ? link_beat.side.first.seq : link_beat.side.second.seq;
         posted_seq_out_second <= link_beat.side.second.seq;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_tag_second_needs_first;
      alloc_tag_second_valid |-> alloc_tag_first_valid;
   endproperty
   a_tag_second_needs_first: assert property (p_tag_second_needs_first)
      else $error("second tag valid without first");

   property p_no_second_unstraddled;
      acc && !straddle_q |=> !alloc_tag_second_valid;
   endproperty
   a_no_second_unstraddled: assert property (p_no_second_unstraddled)
      else $error("second tag valid without straddle");

   property p_tag_pulse;
      internal_q && np0 |=> alloc_tag_first_valid && alloc_tag_first == $past(tag0_sel);
   endproperty
   a_tag_pulse: assert property (p_tag_pulse)
      else $error("allocated tag not reported");

   property p_tag_cause;
      alloc_tag_first_valid |-> $past(internal_q && (np0 || np1));
   endproperty
   a_tag_cause: assert property (p_tag_cause)
      else $error("tag valid with no request");

   property p_table_full_stall;
      $past(internal_q) && internal_q && out_cnt_q >= TABLE_LIMIT |-> !req_stream_ready;
   endproperty
   a_table_full_stall: assert property (p_table_full_stall)
      else $error("ready high with full table");

   property p_hdr_lag;
      !$past(reset) |-> np_header_credit_count == sat4({1'b0, $past(hdr_q)});
   endproperty
   a_hdr_lag: assert property (p_hdr_lag)
      else $error("header credit count wrong");

   property p_data_sat;
      !$past(reset) && $past(data_q) > 8'h0E |-> np_data_credit_count == CNT_SAT;
   endproperty
   a_data_sat: assert property (p_data_sat)
      else $error("data credit count not saturated");

   property p_seq_first;
      pop && slot_posted(link_beat.side.first)
         |=> posted_seq_out_first_valid && posted_seq_out_first == $past(link_beat.side.first.seq);
   endproperty
   a_seq_first: assert property (p_seq_first)
      else $error("posted sequence not reported");

   property p_seq_second_needs_first;
      posted_seq_out_second_valid |-> posted_seq_out_first_valid;
   endproperty
   a_seq_second_needs_first: assert property (p_seq_second_needs_first)
      else $error("second sequence valid alone");

   property p_pend_set;
      np0 |=> pend_q[$past(tag0_sel)];
   endproperty
   a_pend_set: assert property (p_pend_set)
      else $error("pending bit not set");

   c_two_tags: cover property (alloc_tag_first_valid && alloc_tag_second_valid);
   c_two_seq: cover property (posted_seq_out_first_valid && posted_seq_out_second_valid);
   c_stall: cover property (req_stream_valid && !req_stream_ready);
   c_release: cover property (release_tag ##1 cpl_hit);
endmodule
`default_nettype wire

// file: shared/tag_credit_pkg.sv
// constants and carrier types for the requester tag, credit and ordering block
package tag_credit_pkg;
   localparam int TAG_W = 8;
   localparam int NUM_TAGS = 256;
   localparam int SEQ_W = 6;
   localparam logic [8:0] TABLE_LIMIT = 9'h100;
   localparam logic [8:0] FREE_RESET = 9'h100;
   localparam logic [7:0] NPH_INIT = 8'h20;
   localparam logic [7:0] NPD_INIT = 8'h40;
   localparam logic [7:0] CREDIT_MAX = 8'hFF;
   localparam logic [3:0] CNT_SAT = 4'hF;
   localparam logic [8:0] CNT_SAT_WIDE = 9'h00F;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CREDIT = 8'h08;
   localparam int CTRL_INTERNAL_POS = 0;
   localparam int CTRL_STRADDLE_POS = 1;
   localparam logic CTRL_INTERNAL_RST = 1'b1;
   localparam logic CTRL_STRADDLE_RST = 1'b0;
   localparam int STATUS_FREE_POS = 16;
   localparam int CREDIT_NPD_POS = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic start;
      logic np;
      logic has_data;
      logic [TAG_W-1:0] tag;
      logic [SEQ_W-1:0] seq;
   } slot_t;

   typedef struct packed {
      slot_t second;
      slot_t first;
   } sideband_t;

   typedef struct packed {
      logic [63:0] payload;
      sideband_t side;
      logic last;
   } beat_t;

   typedef struct packed {
      logic valid;
      logic last;
      logic [TAG_W-1:0] tag;
   } cpl_t;
endpackage

// file: logic/tag_free_list.sv
// circular list of free tags, up to two taken and one returned per cycle
`timescale 1ns/10ps
`default_nettype none
module tag_free_list (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] pop_cnt,
   input wire logic push,
   input wire logic [tag_credit_pkg::TAG_W-1:0] push_tag,
   output logic [tag_credit_pkg::TAG_W-1:0] head_tag0,
   output logic [tag_credit_pkg::TAG_W-1:0] head_tag1,
   output logic [8:0] count
);
   import tag_credit_pkg::*;

   logic [TAG_W-1:0] mem_q [NUM_TAGS];
   logic [7:0] head_q;
   logic [7:0] tail_q;
   logic [8:0] count_q;

   // every tag starts free, in ascending order
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_TAGS; i++) begin
            mem_q[i] <= 8'(i);
         end
      end else if (push) begin
         mem_q[tail_q] <= push_tag;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         head_q <= 8'h00;
         tail_q <= 8'h00;
         count_q <= FREE_RESET;
      end else begin
         head_q <= head_q + {6'h00, pop_cnt};
         if (push) begin
            tail_q <= tail_q + 8'h01;
         end
         count_q <= count_q + {8'h00, push} - {7'h00, pop_cnt};
      end
   end

   assign head_tag0 = mem_q[head_q];
   assign head_tag1 = mem_q[head_q + 8'h01];
   assign count = count_q;
endmodule
`default_nettype wire

// file: test/link_sink_model.sv
// link receiver model that stalls the transmit side in a fixed pattern
`timescale 1ns/10ps
`default_nettype none
module link_sink_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic link_valid,
   output logic link_ready
);
   import tag_credit_pkg::*;
   logic [1:0] phase_q;
   // ------------------------------------------------------------
   // stall pattern
   // ------------------------------------------------------------
   // one stall in three cycles keeps the two-entry link queue under pressure
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         phase_q <= 2'h0;
      end else if (link_valid) begin
         phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      end
   end
   assign link_ready = !reset && (phase_q != 2'h1);
endmodule
`default_nettype wire

// file: test/tb_requester_tag_credit_ordering.sv
// self-checking bench for tag allocation, credit counts and posted ordering
`timescale 1ns/10ps
`default_nettype none
module tb_requester_tag_credit_ordering;
   import tag_credit_pkg::*;
   logic clk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, req_stream_ready, link_valid, link_ready;
   logic cpl_hit_valid, cpl_hit, alloc_tag_first_valid, alloc_tag_second_valid;
   logic posted_seq_out_first_valid, posted_seq_out_second_valid;
   logic [7:0] awaddr = 0, araddr = 0, alloc_tag_first, alloc_tag_second;
   logic [31:0] wdata = 0, rdata;
   logic [1:0] bresp, rresp;
   logic req_stream_valid = 0, req_stream_last = 0;
   logic [63:0] req_stream_payload = 0;
   sideband_t req_stream_sideband = '0;
   beat_t link_beat;
   cpl_t cpl_in = '0;
   logic [3:0] np_header_credit_count, np_data_credit_count, free_tag_count;
   logic [5:0] posted_seq_out_first, posted_seq_out_second;
   logic [5:0] sq[$];
   logic [7:0] tq[$];
   logic used[256];
   logic [7:0] last_tag;
   int fail_count = 0, comparisons = 0, seed = 7280, nnp = 0, ndata = 0;
   requester_tag_credit_ordering dut_u (.clk(clk), .reset(reset), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .req_stream_valid(req_stream_valid), .req_stream_ready(req_stream_ready),
      .req_stream_sideband(req_stream_sideband), .req_stream_payload(req_stream_payload),
      .req_stream_last(req_stream_last), .link_valid(link_valid), .link_ready(link_ready),
      .link_beat(link_beat), .nph_credit_return(4'h0), .npd_credit_return(4'h0),
      .cpl_in(cpl_in), .cpl_hit_valid(cpl_hit_valid), .cpl_hit(cpl_hit),
      .alloc_tag_first(alloc_tag_first), .alloc_tag_second(alloc_tag_second),
      .alloc_tag_first_valid(alloc_tag_first_valid),
      .alloc_tag_second_valid(alloc_tag_second_valid),
      .np_header_credit_count(np_header_credit_count),
      .np_data_credit_count(np_data_credit_count), .free_tag_count(free_tag_count),
      .posted_seq_out_first(posted_seq_out_first), .posted_seq_out_second(posted_seq_out_second),
      .posted_seq_out_first_valid(posted_seq_out_first_valid),
      .posted_seq_out_second_valid(posted_seq_out_second_valid));
   link_sink_model link_u (.clk(clk), .reset(reset), .link_valid(link_valid),
      .link_ready(link_ready));
   // ------------------------------------------------------------
   // checking helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic timed_out();
      fail_count++;
      tally_and_finish();
   endtask
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   // ready is looked at on the falling edge so the release lands on the taking edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ga, gw;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         if (bvalid === 1'b1) break;
         ga = awready;
         gw = wready;
         @(posedge clk);
         if (ga === 1'b1) awvalid <= 1'b0;
         if (gw === 1'b1) wvalid <= 1'b0;
      end
      if (n == 40) timed_out();
      chk(bresp, RESP_OKAY);
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic g;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge clk);
         if (rvalid === 1'b1) break;
         g = arready;
         @(posedge clk);
         if (g === 1'b1) arvalid <= 1'b0;
      end
      if (n == 40) timed_out();
      chk(rdata, ed);
      chk(rresp, er);
      @(posedge clk);
   endtask
   function automatic slot_t mk(input logic np);
      slot_t s;
      s = '0;
      s.start = 1'b1;
      s.np = np;
      s.has_data = np & 1'($random(seed));
      s.seq = 6'($random(seed));
      return s;
   endfunction
   task automatic note(input slot_t s);
      if (s.start && s.np) begin
         nnp++;
         ndata += s.has_data;
         tq.push_back(8'h00);
      end
      if (s.start && !s.np) sq.push_back(s.seq);
   endtask
   // valid stays up across back-to-back beats; idle lowers it
   task automatic send(input slot_t f, input slot_t s);
      int n;
      logic g;
      req_stream_valid <= 1'b1;
      req_stream_sideband <= '{second: s, first: f};
      req_stream_payload <= {$random(seed), $random(seed)};
      req_stream_last <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(negedge clk);
         g = req_stream_ready;
         @(posedge clk);
         if (g === 1'b1) break;
      end
      if (n == 60) timed_out();
      note(f);
      note(s);
   endtask
   task automatic cpl(input logic [7:0] t, input logic hit);
      cpl_in <= '{valid: 1'b1, last: 1'b1, tag: t};
      @(posedge clk);
      cpl_in <= '0;
      @(negedge clk);
      chk({cpl_hit_valid, cpl_hit}, {1'b1, hit});
      @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // output watcher
   // ------------------------------------------------------------
   always @(negedge clk) begin
      if (!reset && alloc_tag_first_valid === 1'b1) begin
         chk(tq.size() > 0, 1'b1);
         if (tq.size() > 0) void'(tq.pop_front());
         chk(used[alloc_tag_first] === 1'b1, 1'b0);
         used[alloc_tag_first] = 1'b1;
         last_tag = alloc_tag_first;
      end
      if (!reset && alloc_tag_second_valid === 1'b1) begin
         chk({alloc_tag_first_valid, tq.size() > 0}, 2'h3);
         if (tq.size() > 0) void'(tq.pop_front());
         chk(used[alloc_tag_second] === 1'b1, 1'b0);
         used[alloc_tag_second] = 1'b1;
      end
      if (!reset && posted_seq_out_first_valid === 1'b1) begin
         chk(posted_seq_out_first, sq.size() > 0 ? 32'(sq.pop_front()) : 32'h40);
      end
      if (!reset && posted_seq_out_second_valid === 1'b1) begin
         chk(posted_seq_out_second, sq.size() > 0 ? 32'(sq.pop_front()) : 32'h40);
      end
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      forever #2.5 clk = ~clk;
   end
   initial begin
      int i;
      slot_t s;
      for (i = 0; i < 256; i++) used[i] = 1'b0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      chk({np_header_credit_count, np_data_credit_count, free_tag_count}, 12'hFFF);
      axi_rd(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
      axi_rd(8'h0C, 32'h0000_0000, RESP_SLVERR);
      for (i = 0; i < 6; i++) send(mk(i[0] == 1'b0), '0);
      req_stream_valid <= 1'b0;
      axi_wr(ADDR_CTRL, 32'h0000_0003);
      send(mk(1'b1), mk(1'b1));
      send(mk(1'b0), mk(1'b0));
      send(mk(1'b0), mk(1'b1));
      req_stream_valid <= 1'b0;
      repeat (12) @(posedge clk);
      axi_rd(ADDR_CREDIT, {16'h0, NPD_INIT - 8'(ndata), NPH_INIT - 8'(nnp)}, RESP_OKAY);
      axi_rd(ADDR_STATUS, {7'h0, FREE_RESET - 9'(nnp), 7'h0, 9'(nnp)}, RESP_OKAY);
      cpl(last_tag, 1'b1);
      for (i = 0; used[i] === 1'b1 && i < 255; i++);
      cpl(8'(i), 1'b0);
      axi_rd(ADDR_STATUS, {7'h0, FREE_RESET - 9'(nnp - 1), 7'h0, 9'(nnp - 1)}, RESP_OKAY);
      axi_wr(ADDR_CTRL, 32'h0000_0000);
      s = mk(1'b1);
      s.tag = 8'hC3;
      send(s, '0);
      req_stream_valid <= 1'b0;
      repeat (4) @(posedge clk);
      chk(free_tag_count, 4'h0);
      cpl(8'hC3, 1'b1);
      // the external request gets no tag report, so its note stays queued
      chk(tq.size() + sq.size(), 32'h1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
